// ---- common/sph_pkg.sv ----
package sph_pkg;
    // bus widths
    localparam int DATA_W   = 8;
    localparam int ID_W     = 3;
    // command block lengths in bytes
    localparam logic [3:0] CMD_LEN_SHORT = 4'h6;
    localparam logic [3:0] CMD_LEN_LONG  = 4'ha;
    // line level for asserted and released (lines are low true)
    localparam logic LINE_ON  = 1'h0;
    localparam logic LINE_OFF = 1'h1;
    // phase codes as seen on msg/cd/io when asserted (1 = asserted)
    localparam logic [2:0] PH_CMD    = 3'h2;
    localparam logic [2:0] PH_DATAIN = 3'h1;
    localparam logic [2:0] PH_STATUS = 3'h3;
    localparam logic [2:0] PH_MSGIN  = 3'h7;

    // odd parity bit for a byte: data plus parity holds an odd count of ones
    function automatic logic oddPar(input logic [DATA_W-1:0] d);
        oddPar = ~(^d);
    endfunction
endpackage

// ---- common/sph_bus_if.sv ----
`timescale 1ns/1ps
// bus lines carry electrical levels: 0 asserted, 1 released
interface sph_bus_if;
    logic [7:0] dbTgt;     // data driven by target
    logic       dbTgtOe;   // target data enable
    logic [7:0] dbIni;     // data driven by initiator
    logic       dbIniOe;   // initiator data enable
    logic       dbpTgt;    // parity from target
    logic       dbpIni;    // parity from initiator
    logic       selN;      // select
    logic       bsyN;      // busy
    logic       reqN;      // request
    logic       ackN;      // acknowledge
    logic       cdN;       // control/data
    logic       ioN;       // input/output
    logic       msgN;      // message
    logic       rstN;      // bus reset
    logic       atnN;      // attention
    logic [7:0] db;        // resolved data
    logic       dbp;       // resolved parity

    // wired-or of low-true lines; released lines float high
    assign db  = (dbTgtOe ? dbTgt : 8'hff) & (dbIniOe ? dbIni : 8'hff);
    assign dbp = (dbTgtOe ? dbpTgt : 1'h1) & (dbIniOe ? dbpIni : 1'h1);

    modport target (
        output dbTgt, dbTgtOe, dbpTgt, bsyN, reqN, cdN, ioN, msgN,
        input  db, dbp, selN, ackN, rstN, atnN
    );
    modport initiator (
        output dbIni, dbIniOe, dbpIni, selN, ackN, rstN, atnN,
        input  db, dbp, bsyN, reqN, cdN, ioN, msgN
    );
endinterface

// ---- hdl/sph_target.sv ----
`timescale 1ns/1ps
module sph_target (
    input  wire logic       ref_clk,     // 20 MHz clock
    input  wire logic       reset_n,     // async reset, active low
    sph_bus_if.target       bus,         // scsi bus
    input  wire logic [2:0] myId,        // own id bit number
    input  wire logic [7:0] inData,      // data-in byte to send
    input  wire logic       inValid,     // data-in byte available
    output logic            inReady,     // data-in byte taken
    input  wire logic       inLast,      // byte is the last of data phase
    input  wire logic [7:0] statusByte,  // status to report
    input  wire logic [7:0] msgByte,     // message-in byte
    output logic [7:0]      cmdByte,     // received command byte
    output logic            cmdValid,    // pulse per command byte
    output logic            cmdDone,     // pulse at end of command block
    output logic            parityErr,   // pulse on bad command parity
    output logic            busy         // target holds the bus
);
    typedef enum logic [6:0] {
        T_IDLE = 7'h01, T_CMD = 7'h02, T_DIN = 7'h04, T_STAT = 7'h08,
        T_MSG  = 7'h10, T_WAIT = 7'h20, T_FREE = 7'h40
    } sph_tstate_t;

    // two-flop synchronisers on incoming pins
    logic [1:0] selS_r, ackS_r, rstS_r;
    logic [7:0] db1_r, db2_r;
    logic       dbp1_r, dbp2_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            selS_r <= 2'h3;
            ackS_r <= 2'h3;
            rstS_r <= 2'h3;
            db1_r  <= 8'hff;
            db2_r  <= 8'hff;
            dbp1_r <= 1'h1;
            dbp2_r <= 1'h1;
        end else begin
            selS_r <= {selS_r[0], bus.selN};
            ackS_r <= {ackS_r[0], bus.ackN};
            rstS_r <= {rstS_r[0], bus.rstN};
            db1_r  <= bus.db;
            db2_r  <= db1_r;
            dbp1_r <= bus.dbp;
            dbp2_r <= dbp1_r;
        end
    end
    logic selOn, ackOn, rstOn;
    logic [7:0] dbOn;
    assign selOn = (selS_r[1] == sph_pkg::LINE_ON);
    assign ackOn = (ackS_r[1] == sph_pkg::LINE_ON);
    assign rstOn = (rstS_r[1] == sph_pkg::LINE_ON);
    assign dbOn  = ~db2_r;

    sph_tstate_t st_r, st_nxt, ret_r, ret_nxt;
    logic        req_r, req_nxt;
    logic [7:0]  txd_r, txd_nxt, cmd_r, cmd_nxt;
    logic [3:0]  cnt_r, cnt_nxt, len_r, len_nxt;
    logic        last_r, last_nxt, cv_nxt, cd_nxt, pe_nxt;
    logic        cmdValid_r, cmdDone_r, parityErr_r;

    // phase sequencer and byte handshake
    always_comb begin
        st_nxt  = st_r;
        ret_nxt = ret_r;
        req_nxt = req_r;
        txd_nxt = txd_r;
        cmd_nxt = cmd_r;
        cnt_nxt = cnt_r;
        len_nxt = len_r;
        last_nxt = last_r;
        cv_nxt  = 1'h0;
        cd_nxt  = 1'h0;
        pe_nxt  = 1'h0;
        inReady = 1'h0;
        case (st_r)
            T_IDLE: begin
                if (selOn && dbOn[myId]) begin
                    st_nxt  = T_CMD;
                    cnt_nxt = 4'h0;
                    len_nxt = sph_pkg::CMD_LEN_SHORT;
                end
            end
            T_CMD: begin
                if (!req_r && !ackOn && !selOn) begin
                    req_nxt = 1'h1;
                end else if (req_r && ackOn) begin
                    req_nxt = 1'h0;
                    cmd_nxt = dbOn;
                    cv_nxt  = 1'h1;
                    pe_nxt  = (sph_pkg::oddPar(dbOn) != ~dbp2_r);
                    // group 1 and 2 opcodes carry ten byte blocks
                    if (cnt_r == 4'h0 && (dbOn[7:5] == 3'h1 || dbOn[7:5] == 3'h2)) begin
                        len_nxt = sph_pkg::CMD_LEN_LONG;
                    end
                    cnt_nxt = cnt_r + 4'h1;
                    st_nxt  = T_WAIT;
                    ret_nxt = T_CMD;
                end
            end
            T_WAIT: begin
                // host must release ack before next byte or phase
                if (!ackOn) begin
                    if (ret_r == T_CMD && cnt_r == len_r) begin
                        cd_nxt = 1'h1;
                        st_nxt = inValid ? T_DIN : T_STAT;
                    end else begin
                        st_nxt = ret_r;
                    end
                end
            end
            T_DIN: begin
                if (!req_r && inValid) begin
                    txd_nxt  = inData;
                    last_nxt = inLast;
                    inReady  = 1'h1;
                    req_nxt  = 1'h1;
                end else if (req_r && ackOn) begin
                    req_nxt = 1'h0;
                    st_nxt  = T_WAIT;
                    ret_nxt = last_r ? T_STAT : T_DIN;
                end
            end
            T_STAT: begin
                if (!req_r && ret_r != T_MSG) begin
                    txd_nxt = statusByte;
                    req_nxt = 1'h1;
                    ret_nxt = T_STAT;
                end else if (req_r && ackOn) begin
                    req_nxt = 1'h0;
                    st_nxt  = T_WAIT;
                    ret_nxt = T_MSG;
                end
            end
            T_MSG: begin
                if (!req_r && ret_r == T_MSG) begin
                    txd_nxt = msgByte;
                    req_nxt = 1'h1;
                    ret_nxt = T_IDLE;
                end else if (req_r && ackOn) begin
                    req_nxt = 1'h0;
                    st_nxt  = T_WAIT;
                    ret_nxt = T_FREE;
                end
            end
            T_FREE: begin
                st_nxt = T_IDLE;
            end
            default: st_nxt = T_IDLE;
        endcase
        // wait back to msg keeps return marker intact
        if (st_r == T_WAIT && !ackOn && ret_r == T_MSG) begin
            st_nxt  = T_MSG;
        end
        if (rstOn) begin
            st_nxt  = T_IDLE;
            req_nxt = 1'h0;
        end
    end

    // state registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r        <= T_IDLE;
            ret_r       <= T_IDLE;
            req_r       <= 1'h0;
            txd_r       <= 8'h00;
            cmd_r       <= 8'h00;
            cnt_r       <= 4'h0;
            len_r       <= 4'h0;
            last_r      <= 1'h0;
            cmdValid_r  <= 1'h0;
            cmdDone_r   <= 1'h0;
            parityErr_r <= 1'h0;
        end else begin
            st_r        <= st_nxt;
            ret_r       <= ret_nxt;
            req_r       <= req_nxt;
            txd_r       <= txd_nxt;
            cmd_r       <= cmd_nxt;
            cnt_r       <= cnt_nxt;
            len_r       <= len_nxt;
            last_r      <= last_nxt;
            cmdValid_r  <= cv_nxt;
            cmdDone_r   <= cd_nxt;
            parityErr_r <= pe_nxt;
        end
    end

    // bus drive: phase lines held through wait so phase stays stable
    logic inPh, cmdPh, drive;
    assign inPh  = (st_r == T_DIN) || (st_r == T_STAT) || (st_r == T_MSG) ||
                   (st_r == T_WAIT && ret_r != T_CMD);
    assign cmdPh = (st_r == T_CMD) || (st_r == T_WAIT && ret_r == T_CMD);
    assign drive = inPh && req_r;
    assign busy  = (st_r != T_IDLE);
    assign bus.bsyN    = busy ? sph_pkg::LINE_ON : sph_pkg::LINE_OFF;
    assign bus.reqN    = ~req_r;
    assign bus.ioN     = ~inPh;
    assign bus.cdN     = ~(cmdPh || st_r == T_STAT || st_r == T_MSG ||
                           (st_r == T_WAIT && (ret_r == T_MSG || ret_r == T_FREE)));
    assign bus.msgN    = ~(st_r == T_MSG || (st_r == T_WAIT && ret_r == T_FREE));
    assign bus.dbTgtOe = drive;
    assign bus.dbTgt   = ~txd_r;
    assign bus.dbpTgt  = ~sph_pkg::oddPar(txd_r);
    assign cmdByte     = cmd_r;
    assign cmdValid    = cmdValid_r;
    assign cmdDone     = cmdDone_r;
    assign parityErr   = parityErr_r;
endmodule

// ---- hdl/sph_initiator.sv ----
`timescale 1ns/1ps
module sph_initiator (
    input  wire logic       ref_clk,    // 20 MHz clock
    input  wire logic       reset_n,    // async reset, active low
    sph_bus_if.initiator    bus,        // scsi bus
    input  wire logic       start,      // pulse: begin selection
    input  wire logic [2:0] tgtId,      // wanted target id
    input  wire logic [7:0] cmdData,    // next command byte
    output logic            cmdReady,   // command byte taken
    input  wire logic       busRst,     // level: drive bus reset
    output logic [7:0]      rxByte,     // byte received from target
    output logic            rxValid,    // pulse per received byte
    output logic [2:0]      rxPhase,    // phase of received byte
    output logic            parityErr,  // pulse on bad received parity
    output logic            active      // selection or transfer ongoing
);
    typedef enum logic [3:0] {
        I_IDLE = 4'h1, I_ARB = 4'h2, I_SEL = 4'h4, I_XFER = 4'h8
    } sph_istate_t;

    // synchronisers
    logic [1:0] bsyS_r, reqS_r;
    logic [2:0] ph1_r, ph2_r;
    logic [7:0] db1_r, db2_r;
    logic       dbp1_r, dbp2_r;
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            bsyS_r <= 2'h3;
            reqS_r <= 2'h3;
            ph1_r  <= 3'h7;
            ph2_r  <= 3'h7;
            db1_r  <= 8'hff;
            db2_r  <= 8'hff;
            dbp1_r <= 1'h1;
            dbp2_r <= 1'h1;
        end else begin
            bsyS_r <= {bsyS_r[0], bus.bsyN};
            reqS_r <= {reqS_r[0], bus.reqN};
            ph1_r  <= {bus.msgN, bus.cdN, bus.ioN};
            ph2_r  <= ph1_r;
            db1_r  <= bus.db;
            db2_r  <= db1_r;
            dbp1_r <= bus.dbp;
            dbp2_r <= dbp1_r;
        end
    end
    logic bsyOn, reqOn, ioOn;
    logic [2:0] ph;
    assign bsyOn = ~bsyS_r[1];
    assign reqOn = ~reqS_r[1];
    assign ph    = ~ph2_r;
    assign ioOn  = ph[0];

    sph_istate_t st_r, st_nxt;
    logic        ack_r, ack_nxt, sel_r, sel_nxt, oe_r, oe_nxt;
    logic [7:0]  out_r, out_nxt, rx_r, rx_nxt;
    logic [2:0]  rph_r, rph_nxt;
    logic        rv_nxt, rv_r, pe_nxt, pe_r;

    // selection and per-byte handshake
    always_comb begin
        st_nxt   = st_r;
        ack_nxt  = ack_r;
        sel_nxt  = sel_r;
        oe_nxt   = oe_r;
        out_nxt  = out_r;
        rx_nxt   = rx_r;
        rph_nxt  = rph_r;
        rv_nxt   = 1'h0;
        pe_nxt   = 1'h0;
        cmdReady = 1'h0;
        case (st_r)
            I_IDLE: begin
                if (start && !bsyOn) begin
                    out_nxt = 8'h01 << tgtId;
                    oe_nxt  = 1'h1;
                    st_nxt  = I_ARB;
                end
            end
            I_ARB: begin
                sel_nxt = 1'h1;  // id first, select after
                st_nxt  = I_SEL;
            end
            I_SEL: begin
                if (bsyOn) begin
                    sel_nxt = 1'h0;
                    oe_nxt  = 1'h0;
                    st_nxt  = I_XFER;
                end
            end
            I_XFER: begin
                if (!bsyOn) begin
                    st_nxt  = I_IDLE;
                    ack_nxt = 1'h0;
                    oe_nxt  = 1'h0;
                end else if (reqOn && !ack_r) begin
                    if (!ioOn) begin
                        out_nxt  = cmdData;
                        oe_nxt   = 1'h1;
                        cmdReady = 1'h1;
                        ack_nxt  = 1'h1;
                    end else if (oe_r) begin
                        oe_nxt = 1'h0;  // release before reading
                    end else begin
                        rx_nxt  = ~db2_r;
                        rph_nxt = ph;
                        rv_nxt  = 1'h1;
                        pe_nxt  = (sph_pkg::oddPar(~db2_r) != ~dbp2_r);
                        ack_nxt = 1'h1;
                    end
                end else if (!reqOn && ack_r) begin
                    ack_nxt = 1'h0;
                    oe_nxt  = 1'h0;
                end
            end
            default: st_nxt = I_IDLE;
        endcase
    end

    // state registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_r  <= I_IDLE;
            ack_r <= 1'h0;
            sel_r <= 1'h0;
            oe_r  <= 1'h0;
            out_r <= 8'h00;
            rx_r  <= 8'h00;
            rph_r <= 3'h0;
            rv_r  <= 1'h0;
            pe_r  <= 1'h0;
        end else begin
            st_r  <= st_nxt;
            ack_r <= ack_nxt;
            sel_r <= sel_nxt;
            oe_r  <= oe_nxt;
            out_r <= out_nxt;
            rx_r  <= rx_nxt;
            rph_r <= rph_nxt;
            rv_r  <= rv_nxt;
            pe_r  <= pe_nxt;
        end
    end

    // low-true bus drive; attention unused and held released
    assign bus.dbIni   = ~out_r;
    assign bus.dbIniOe = oe_r;
    assign bus.dbpIni  = ~sph_pkg::oddPar(out_r);
    assign bus.selN    = ~sel_r;
    assign bus.ackN    = ~ack_r;
    assign bus.rstN    = ~busRst;
    assign bus.atnN    = sph_pkg::LINE_OFF;
    assign rxByte      = rx_r;
    assign rxValid     = rv_r;
    assign rxPhase     = rph_r;
    assign parityErr   = pe_r;
    assign active      = (st_r != I_IDLE);
endmodule

// ---- bench/sph_bus_checker.sv ----
`timescale 1ns/1ps
module sph_bus_checker #(
    parameter int TGT_ID = 0
) (
    input wire logic       ref_clk,  // bench clock
    input wire logic       reset_n,  // async reset, active low
    input wire logic [7:0] dbTgt,    // target data
    input wire logic       dbTgtOe,  // target data enable
    input wire logic       dbpTgt,   // target parity
    input wire logic [7:0] dbIni,    // initiator data
    input wire logic       dbIniOe,  // initiator data enable
    input wire logic       dbpIni,   // initiator parity
    input wire logic       selN,     // select
    input wire logic       bsyN,     // busy
    input wire logic       reqN,     // request
    input wire logic       ackN,     // acknowledge
    input wire logic       cdN,      // control/data
    input wire logic       ioN,      // input/output
    input wire logic       msgN,     // message
    input wire logic       rstN,     // bus reset
    input wire logic [7:0] db        // resolved data
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // busy, request, select and acknowledge released on leaving reset
    property p_idle; $rose(reset_n) |-> bsyN && reqN && selN && ackN; endproperty
    a_idle: assert property (p_idle) else $error("bus not idle after reset");
    property p_selId; $fell(selN) |-> !db[TGT_ID]; endproperty
    a_selId: assert property (p_selId) else $error("select without id bit");
    property p_bsyAns; $fell(selN) && !db[TGT_ID] |-> ##[1:8] !bsyN; endproperty
    a_bsyAns: assert property (p_bsyAns) else $error("busy not answered");
    property p_ackAns; $fell(reqN) |-> ##[1:8] (!ackN || !rstN); endproperty
    a_ackAns: assert property (p_ackAns) else $error("ack not answered");
    property p_reqHold; !reqN && ackN && rstN |=> !reqN; endproperty
    a_reqHold: assert property (p_reqHold) else $error("req dropped before ack");
    property p_ackCause; $fell(ackN) |-> !reqN; endproperty
    a_ackCause: assert property (p_ackCause) else $error("ack without req");
    property p_ackHold; !ackN && !reqN && rstN |=> !ackN; endproperty
    a_ackHold: assert property (p_ackHold) else $error("ack dropped before req");
    property p_reqNext; $fell(reqN) |-> ackN; endproperty
    a_reqNext: assert property (p_reqNext) else $error("req while ack held");
    // the direction line decides who may drive data; a clash corrupts the byte
    property p_dirIni; dbIniOe |-> ioN && !dbTgtOe; endproperty
    a_dirIni: assert property (p_dirIni) else $error("initiator drives in input phase");
    property p_dirTgt; !reqN && !ioN |-> dbTgtOe; endproperty
    a_dirTgt: assert property (p_dirTgt) else $error("input byte not driven");
    property p_parTgt; !reqN && dbTgtOe |-> (^{dbTgt, dbpTgt}) == 1'h0; endproperty
    a_parTgt: assert property (p_parTgt) else $error("target parity wrong");
    property p_parIni; !ackN && dbIniOe |-> (^{dbIni, dbpIni}) == 1'h0; endproperty
    a_parIni: assert property (p_parIni) else $error("initiator parity wrong");
    property p_phHold; !reqN ##1 !reqN |-> $stable({cdN, ioN, msgN}); endproperty
    a_phHold: assert property (p_phHold) else $error("phase changed in byte");
    property p_msgPh; !msgN && rstN |-> !cdN && !ioN; endproperty
    a_msgPh: assert property (p_msgPh) else $error("message phase lines wrong");
endmodule

// ---- bench/scsi_phase_handshake_tb_top.sv ----
`timescale 1ns/1ps
module scsi_phase_handshake_tb_top;
    localparam int TGT_ID = 5;
    logic        ref_clk = 1'h0;
    logic        reset_n = 1'h0;
    logic        start, busRst, inValid, inLast, inReady, cmdReady, cmdValid, cmdDone;
    logic        tPar, iPar, busy, active, rxValid;
    logic [2:0]  myId, tgtId, rxPhase;
    logic [7:0]  cmdData, inData, statusByte, msgByte, cmdByte, rxByte;
    logic [7:0]  cmdArr [10];
    logic [7:0]  inArr [4];
    logic [7:0]  cmdQ [$];
    logic [10:0] rxQ [$];
    logic [31:0] seed = 32'h32;
    int          cmdIdx, inIdx, inCnt, nDone, fail_count, n_compared, t;

    always #25 ref_clk = ~ref_clk;

    sph_bus_if bus ();
    sph_target i_sph_target (.ref_clk, .reset_n, .bus(bus), .myId, .inData, .inValid, .inReady, .inLast,
        .statusByte, .msgByte, .cmdByte, .cmdValid, .cmdDone, .parityErr(tPar), .busy);
    sph_initiator i_sph_initiator (.ref_clk, .reset_n, .bus(bus), .start, .tgtId, .cmdData, .cmdReady,
        .busRst, .rxByte, .rxValid, .rxPhase, .parityErr(iPar), .active);
    sph_bus_checker #(.TGT_ID(TGT_ID)) i_sph_bus_checker (.ref_clk, .reset_n, .dbTgt(bus.dbTgt),
        .dbTgtOe(bus.dbTgtOe), .dbpTgt(bus.dbpTgt), .dbIni(bus.dbIni), .dbIniOe(bus.dbIniOe),
        .dbpIni(bus.dbpIni), .selN(bus.selN), .bsyN(bus.bsyN), .reqN(bus.reqN), .ackN(bus.ackN),
        .cdN(bus.cdN), .ioN(bus.ioN), .msgN(bus.msgN), .rstN(bus.rstN), .db(bus.db));

    // user streams follow indices that only move on taken bytes
    assign cmdData = cmdArr[cmdIdx % 10];
    assign inData  = inArr[inIdx % 4];
    assign inValid = inIdx < inCnt;
    assign inLast  = inIdx == inCnt - 1;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // block length follows the opcode group
    function automatic logic [3:0] expLen(input logic [2:0] grp);
        return (grp == 3'h1 || grp == 3'h2) ? sph_pkg::CMD_LEN_LONG : sph_pkg::CMD_LEN_SHORT;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        if (fail_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // bounded wait for a count of command bytes; a hang ends the run
    task automatic waitCmd(input int n);
        int i;
        for (i = 0; i < 3000 && cmdQ.size() < n; i++) @(posedge ref_clk);
        if (i == 3000) begin
            chk(16'hdead, 16'h0);
            finish_test();
        end
    endtask

    task automatic waitIdle(input int need);
        int i;
        for (i = 0; i < 4000 && !(rxQ.size() == need && active === 1'h0 && busy === 1'h0); i++)
            @(posedge ref_clk);
        if (i == 4000) begin
            chk(16'hbeef, 16'h0);
            finish_test();
        end
    endtask

    // one full exchange; abort cuts it with a bus reset, again pulses start while busy
    task automatic xfer(input logic [2:0] grp, input int nData, input bit abort, input bit again);
        int          i;
        logic [3:0]  len;
        logic [31:0] r;
        cmdQ.delete();
        rxQ.delete();
        len = expLen(grp);
        r = rnd();
        cmdArr[0] <= {grp, r[4:0]};
        for (i = 1; i < 10; i++) cmdArr[i] <= 8'(rnd());
        for (i = 0; i < 4; i++) inArr[i] <= 8'(rnd());
        statusByte <= 8'(rnd());
        msgByte    <= 8'(rnd());
        cmdIdx     <= 0;
        inIdx      <= 0;
        inCnt      <= nData;
        nDone      <= 0;
        start      <= 1'h1;
        @(posedge ref_clk) start <= 1'h0;
        if (abort) begin
            waitCmd(3);
            busRst <= 1'h1;
            repeat (4) @(posedge ref_clk);
            busRst <= 1'h0;
            waitIdle(0);
            chk({bus.bsyN, bus.reqN, bus.cdN, bus.ioN, bus.msgN}, 5'h1f);
            return;
        end
        if (again) begin
            waitCmd(2);
            start <= 1'h1;
            @(posedge ref_clk) start <= 1'h0;
        end
        waitIdle(nData + 2);
        chk(cmdQ.size(), len);
        chk(nDone, 1);
        for (i = 0; i < len && i < cmdQ.size(); i++) chk(cmdQ[i], cmdArr[i]);
        for (i = 0; i < nData; i++) chk(rxQ[i], {sph_pkg::PH_DATAIN, inArr[i]});
        chk(rxQ[nData], {sph_pkg::PH_STATUS, statusByte});
        chk(rxQ[nData + 1], {sph_pkg::PH_MSGIN, msgByte});
    endtask

    // monitor: user outputs into queues, wire checks on the resolved bus
    always @(posedge ref_clk) begin
        if (cmdReady === 1'h1) cmdIdx <= cmdIdx + 1;
        if (inReady === 1'h1) inIdx <= inIdx + 1;
        if (cmdValid === 1'h1) cmdQ.push_back(cmdByte);
        if (cmdDone === 1'h1) nDone <= nDone + 1;
        if (rxValid === 1'h1) rxQ.push_back({rxPhase, rxByte});
        if (tPar === 1'h1 || iPar === 1'h1) chk(16'h1, 16'h0);
        if (reset_n && $fell(bus.selN)) chk(bus.db[TGT_ID], 1'h0);
        if (!bus.reqN && !bus.ackN) chk(^{bus.db, bus.dbp}, 1'h0);
    end

    // main sequence: opcode groups 0 to 5, data lengths 0 to 4, a refused start, a bus reset
    initial begin
        start      = 1'h0;
        busRst     = 1'h0;
        myId       = 3'(TGT_ID);
        tgtId      = 3'(TGT_ID);
        statusByte = 8'h00;
        msgByte    = 8'h00;
        for (t = 0; t < 10; t++) cmdArr[t] = 8'h00;
        for (t = 0; t < 4; t++) inArr[t] = 8'h00;
        repeat (6) @(posedge ref_clk);
        reset_n <= 1'h1;
        repeat (2) @(posedge ref_clk);
        chk({bus.selN, bus.bsyN, bus.reqN, bus.ackN, bus.rstN, bus.cdN, bus.ioN, bus.msgN}, 8'hff);
        for (t = 0; t < 6; t++) xfer(3'(t), t % 5, 1'b0, t == 3);
        xfer(3'h1, 2, 1'b1, 1'b0);
        xfer(3'h2, 3, 1'b0, 1'b0);
        finish_test();
    end
endmodule
